// >>> lcic_checker.sv
`timescale 1ns/1ps
module lcic_checker #(
  parameter int unsigned START_CYC = 20,
  parameter int unsigned OFF_CYC = 40
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_overvoltage_guard,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic o_pump_en,
  input wire logic o_first_led_sink_en,
  input wire logic o_second_led_sink_en,
  input wire logic o_second_led_fixed,
  input wire logic o_indicator_mode,
  input wire lcic_pkg::lcic_code_t o_reference_current,
  input wire logic o_pump_ready,
  input wire logic o_pump_discharged
);
  import lcic_pkg::*;
  // -----
  // Checks
  // -----
  int unsigned on_cnt;
  int unsigned off_cnt;
  sequence overvolt_held;
    i_overvoltage_guard [*4];
  endsequence
  sequence ack_begin;
    $rose(o_sda_oe);
  endsequence
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      on_cnt <= 0;
      off_cnt <= 0;
    end
    else
    begin
      on_cnt <= o_pump_en ? on_cnt + 32'(on_cnt < START_CYC + 9) : 0;
      off_cnt <= o_pump_en ? 0 : off_cnt + 32'(off_cnt < OFF_CYC + 9);
    end
  end
  sda_low_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_sda_oe |-> !o_sda) else $error("device drove sda high");
  ack_one_bit_a: assert property (@(negedge i_scl) disable iff (i_rst)
    ack_begin |=> $fell(o_sda_oe)) else $error("ack longer than one bit");
  ind_sinks_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_indicator_mode |-> !o_first_led_sink_en && o_second_led_fixed) else $error("ind sinks");
  ind_pump_off_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_indicator_mode |-> !o_pump_en) else $error("pump on in indicator mode");
  ind_code_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_indicator_mode |-> o_reference_current == 5'h00) else $error("code in ind mode");
  normal_sinks_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_first_led_sink_en |-> o_second_led_sink_en && !o_second_led_fixed) else $error("sinks");
  zero_off_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !o_indicator_mode && !o_first_led_sink_en |-> !o_pump_en && !o_second_led_sink_en)
    else $error("off state not clean");
  overvolt_halt_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    overvolt_held |-> !o_pump_en) else $error("pump ran in overvoltage");
  ready_time_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (o_pump_ready && o_pump_en |-> on_cnt >= START_CYC - 1)
    and (on_cnt == START_CYC + 2 |-> o_pump_ready)) else $error("ready timing");
  off_time_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (o_pump_discharged && !o_pump_en |-> off_cnt >= OFF_CYC - 1)
    and (off_cnt == OFF_CYC + 2 |-> o_pump_discharged)) else $error("discharge timing");
endmodule
bind lcic_top lcic_checker #(.START_CYC(START_CYC), .OFF_CYC(OFF_CYC)) u_chk (.i_clk_sys,
  .i_rst, .i_scl, .i_overvoltage_guard, .o_sda, .o_sda_oe, .o_pump_en, .o_first_led_sink_en,
  .o_second_led_sink_en, .o_second_led_fixed, .o_indicator_mode, .o_reference_current,
  .o_pump_ready, .o_pump_discharged);

// >>> lcic_host.sv
`timescale 1ns/1ps
module lcic_host (
  output logic o_scl,
  output logic o_sda,
  input wire logic i_sda_wire
);
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic put(input logic b);
    o_sda = b;
    #40 o_scl = 1'b1;
    #80 o_scl = 1'b0;
    #40;
  endtask
  task automatic frame(input logic [23:0] f, output logic [2:0] ack);
    // Offset keeps link edges clear of system clock edges
    #13;
    o_sda = 1'b0;
    #80 o_scl = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      for (int j = 7; j >= 0; j--)
        put(f[8 * (2 - i) + j]);
      o_sda = 1'b1;
      #40 o_scl = 1'b1;
      ack[2 - i] = ~i_sda_wire;
      #80 o_scl = 1'b0;
      #40;
    end
    o_sda = 1'b0;
    #40 o_scl = 1'b1;
    #40 o_sda = 1'b1;
    #80;
  endtask
endmodule

// >>> lcic_pkg.sv
package lcic_pkg;

  typedef enum logic [1:0] {
    LCIC_ST_IGNORE = 2'b00,
    LCIC_ST_ADDR = 2'b01,
    LCIC_ST_INDEX = 2'b10,
    LCIC_ST_DATA = 2'b11
  } lcic_link_state_t;

  typedef logic [7:0] lcic_byte_t;
  typedef logic [4:0] lcic_code_t;

endpackage

// >>> lcic_regs.svh
`ifndef LCIC_REGS_SVH
`define LCIC_REGS_SVH

// Bus address and register index
`define LCIC_DEV_ADDR 7'h4F
`define LCIC_RW_READ 1'h1
`define LCIC_CTRL_INDEX 8'h01
`define LCIC_CTRL_RESET 8'h00

// Control register fields
`define LCIC_RSVD_HI 7
`define LCIC_RSVD_LO 6
`define LCIC_INDICATOR_MODE_BIT 5
`define LCIC_CODE_HI 4
`define LCIC_CODE_LO 0
`define LCIC_ACTIVE_MASK 8'h3F

// Serial bit positions
`define LCIC_BIT_LAST 4'h7
`define LCIC_BIT_ACK 4'h8

// Converter timing
`define LCIC_CLK_MHZ 125
`define LCIC_T_START_US 150
`define LCIC_T_OFF_US 300
`define LCIC_START_CYC (`LCIC_T_START_US * `LCIC_CLK_MHZ)
`define LCIC_OFF_CYC (`LCIC_T_OFF_US * `LCIC_CLK_MHZ)

`endif

// >>> lcic_settle_timer.sv
`timescale 1ns/1ps
module lcic_settle_timer #(
  parameter int unsigned CYC = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_arm,
  output logic o_done
);
  import lcic_pkg::*;

  logic [31:0] cnt_r;

  // ----------------------------------------
  // Counts while armed, done after CYC cycles
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_r <= 32'h0;
      o_done <= 1'b0;
    end
    else if (!i_arm)
    begin
      cnt_r <= 32'h0;
      o_done <= 1'b0;
    end
    else if (cnt_r < CYC - 32'h1)
    begin
      cnt_r <= cnt_r + 32'h1;
    end
    else
    begin
      o_done <= 1'b1;
    end
  end
endmodule

// >>> lcic_sync2.sv
`timescale 1ns/1ps
module lcic_sync2 (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_sync
);
  import lcic_pkg::*;

  logic meta_r;

  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_r <= 1'b0;
      o_sync <= 1'b0;
    end
    else
    begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule

// >>> lcic_top.sv
// Summary of operation
// - Answer only address 1001111; eighth bit of first byte is read/write flag.
// - Data line driven only to acknowledge; no data byte is ever returned.
// - Bits 7 and 6 are reserved and affect nothing.
// - Indicator bit low, code nonzero: both sinks enabled, current programmable up to 31 mA.
// - Indicator bit high: first sink off, second sink at fixed 450 uA.
// - Indicator mode keeps converter off and first LED disconnected.
// - Current code is latched on the data byte's eighth clock and reaches the reference on the fourth system clock edge after it.
// - Code is binary weighted, bit 0 sixteen times reference, 1 mA per step.
// - Register all zero: converter off, both sinks disconnected.
// - Code dims only in normal mode; indicator mode ignores it.
// - Overvoltage halts converter, resumes automatically when it clears.
// - Converter reaches full load about 150 us after an enabling write.
// - Converter output falls to 5 percent about 300 us after disabling.
`timescale 1ns/1ps
`include "lcic_regs.svh"
module lcic_top #(
  parameter int unsigned START_CYC = `LCIC_START_CYC,
  parameter int unsigned OFF_CYC = `LCIC_OFF_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input wire logic i_overvoltage_guard,
  output logic o_pump_en,
  output logic o_first_led_sink_en,
  output logic o_second_led_sink_en,
  output logic o_second_led_fixed,
  output logic o_indicator_mode,
  output lcic_pkg::lcic_code_t o_reference_current,
  output logic o_pump_ready,
  output logic o_pump_discharged
);
  import lcic_pkg::*;

  // Decision on a completed byte
  function automatic logic addr_match(input lcic_byte_t b);
    addr_match = (b[7:1] == `LCIC_DEV_ADDR) && (b[0] != `LCIC_RW_READ);
  endfunction

  // ----------------------------------------
  // Start detection on the link
  // ----------------------------------------
  logic start_tgl_r;

  always_ff @(negedge i_sda or posedge i_rst)
  begin
    if (i_rst)
    begin
      start_tgl_r <= 1'b0;
    end
    else if (i_scl)
    begin
      start_tgl_r <= ~start_tgl_r;
    end
  end

  // ----------------------------------------
  // Link receiver, clocked by the serial clock
  // ----------------------------------------
  lcic_link_state_t state_r;
  logic start_seen_r;
  logic [3:0] bit_cnt_r;
  logic [6:0] shift_r;
  logic ack_r;
  lcic_byte_t link_data_r;
  logic link_wr_tgl_r;
  logic new_frame;
  lcic_byte_t byte_in;

  assign new_frame = start_tgl_r != start_seen_r;
  assign byte_in = {shift_r, i_sda};

  always_ff @(posedge i_scl or posedge i_rst)
  begin
    if (i_rst)
    begin
      start_seen_r <= 1'b0;
      bit_cnt_r <= 4'h0;
      shift_r <= 7'h00;
    end
    else if (new_frame)
    begin
      start_seen_r <= start_tgl_r;
      bit_cnt_r <= 4'h1;
      shift_r <= {6'h00, i_sda};
    end
    else if (bit_cnt_r == `LCIC_BIT_ACK)
    begin
      bit_cnt_r <= 4'h0;
    end
    else
    begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      shift_r <= byte_in[6:0];
    end
  end

  always_ff @(posedge i_scl or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_r <= LCIC_ST_IGNORE;
      ack_r <= 1'b0;
    end
    else if (new_frame)
    begin
      state_r <= LCIC_ST_ADDR;
      ack_r <= 1'b0;
    end
    else if (bit_cnt_r == `LCIC_BIT_LAST)
    begin
      case (state_r)
        LCIC_ST_ADDR:
        begin
          if (addr_match(byte_in))
          begin
            state_r <= LCIC_ST_INDEX;
            ack_r <= 1'b1;
          end
          else
          begin
            state_r <= LCIC_ST_IGNORE;
            ack_r <= 1'b0;
          end
        end
        LCIC_ST_INDEX:
        begin
          if (byte_in == `LCIC_CTRL_INDEX)
          begin
            state_r <= LCIC_ST_DATA;
            ack_r <= 1'b1;
          end
          else
          begin
            state_r <= LCIC_ST_IGNORE;
            ack_r <= 1'b0;
          end
        end
        LCIC_ST_DATA:
        begin
          state_r <= LCIC_ST_IGNORE;
          ack_r <= 1'b1;
        end
        default:
        begin
          state_r <= LCIC_ST_IGNORE;
          ack_r <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Data byte capture on its eighth clock
  // ----------------------------------------
  always_ff @(posedge i_scl or posedge i_rst)
  begin
    if (i_rst)
    begin
      link_data_r <= `LCIC_CTRL_RESET;
      link_wr_tgl_r <= 1'b0;
    end
    else if (!new_frame && bit_cnt_r == `LCIC_BIT_LAST && state_r == LCIC_ST_DATA)
    begin
      link_data_r <= byte_in;
      link_wr_tgl_r <= ~link_wr_tgl_r;
    end
  end

  // ----------------------------------------
  // Acknowledge drive on the falling edge
  // ----------------------------------------
  always_ff @(negedge i_scl or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_sda_oe <= 1'b0;
      o_sda <= 1'b0;
    end
    else
    begin
      o_sda_oe <= ack_r && (bit_cnt_r == `LCIC_BIT_ACK) && !new_frame;
      o_sda <= 1'b0;
    end
  end

  // ----------------------------------------
  // Crossing into the system clock
  // ----------------------------------------
  logic wr_tgl_sync;
  logic wr_seen_r;
  logic overvolt_sync;

  lcic_sync2 u_wr_sync (
    .i_clk(i_clk_sys),
    .i_rst(i_rst),
    .i_async(link_wr_tgl_r),
    .o_sync(wr_tgl_sync)
  );

  lcic_sync2 u_overvolt_sync (
    .i_clk(i_clk_sys),
    .i_rst(i_rst),
    .i_async(i_overvoltage_guard),
    .o_sync(overvolt_sync)
  );

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  lcic_byte_t ctrl_r;

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      ctrl_r <= `LCIC_CTRL_RESET;
      wr_seen_r <= 1'b0;
    end
    else
    begin
      wr_seen_r <= wr_tgl_sync;
      // Word is stable long before its toggle arrives
      if (wr_tgl_sync != wr_seen_r)
      begin
        ctrl_r <= link_data_r;
      end
    end
  end

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  logic active;
  logic indicator_mode;
  logic pump_en_nxt;
  logic first_en_nxt;
  logic second_en_nxt;
  lcic_code_t ref_nxt;

  always_comb
  begin
    active = (ctrl_r & `LCIC_ACTIVE_MASK) != 8'h00;
    indicator_mode = ctrl_r[`LCIC_INDICATOR_MODE_BIT];
    pump_en_nxt = active && !indicator_mode && !overvolt_sync;
    first_en_nxt = active && !indicator_mode;
    second_en_nxt = active;
    ref_nxt = indicator_mode ? 5'h00 : ctrl_r[`LCIC_CODE_HI:`LCIC_CODE_LO];
  end

  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_pump_en <= 1'b0;
      o_first_led_sink_en <= 1'b0;
      o_second_led_sink_en <= 1'b0;
      o_second_led_fixed <= 1'b0;
      o_indicator_mode <= 1'b0;
      o_reference_current <= 5'h00;
    end
    else
    begin
      o_pump_en <= pump_en_nxt;
      o_first_led_sink_en <= first_en_nxt;
      o_second_led_sink_en <= second_en_nxt;
      o_second_led_fixed <= active && indicator_mode;
      o_indicator_mode <= indicator_mode;
      o_reference_current <= ref_nxt;
    end
  end

  // ----------------------------------------
  // Converter settle status
  // ----------------------------------------
  // start-up time
  lcic_settle_timer #(.CYC(START_CYC)) u_start_tmr (
    .i_clk(i_clk_sys),
    .i_rst(i_rst),
    .i_arm(o_pump_en),
    .o_done(o_pump_ready)
  );

  lcic_settle_timer #(.CYC(OFF_CYC)) u_off_tmr (
    .i_clk(i_clk_sys),
    .i_rst(i_rst),
    .i_arm(!o_pump_en),
    .o_done(o_pump_discharged)
  );
endmodule

// >>> led_current_i2c_control_bench.sv
`timescale 1ns/1ps
module led_current_i2c_control_bench;
  import lcic_pkg::*;
  // -----
  // Bench
  // -----
  logic clk = 1'b0;
  logic rst = 1'b0;
  logic overvolt = 1'b0;
  logic scl, hsda, sda_o, sda_oe, pump, s1, s2, fix, ind, rdy, dis;
  lcic_code_t code;
  logic [2:0] ack;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  wire logic sda_w = hsda & ~(sda_oe & ~sda_o);
  initial
  begin
    forever #4 clk = ~clk;
  end
  lcic_host u_host (.o_scl(scl), .o_sda(hsda), .i_sda_wire(sda_w));
  lcic_top #(.START_CYC(20), .OFF_CYC(40)) u_dut (.i_clk_sys(clk), .i_rst(rst), .i_scl(scl),
    .i_sda(sda_w), .o_sda(sda_o), .o_sda_oe(sda_oe), .i_overvoltage_guard(overvolt),
    .o_pump_en(pump), .o_first_led_sink_en(s1), .o_second_led_sink_en(s2),
    .o_second_led_fixed(fix), .o_indicator_mode(ind), .o_reference_current(code),
    .o_pump_ready(rdy), .o_pump_discharged(dis));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_total++;
      wrap_up;
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [23:0] f, input logic [2:0] ea);
    u_host.frame(f, ack);
    chk("ack", {5'h0, ea}, {5'h0, ack});
    repeat (8) @(negedge clk);
  endtask
  task automatic exp_out(input logic [7:0] v);
    logic z;
    logic m;
    z = (v[5:0] == 6'h00);
    m = v[5];
    chk("flags", {3'h0, ~m & ~z, ~m & ~z, ~z, m, m}, {3'h0, pump, s1, s2, fix, ind});
    chk("code", {3'h0, m ? 5'h00 : v[4:0]}, {3'h0, code});
  endtask
  task automatic t_codes;
    for (int i = 0; i < 5; i++)
    begin
      wr({16'h9E01, 8'h01 << i}, 3'h7);
      exp_out(8'h01 << i);
    end
    wr(24'h9E011E, 3'h7);
    exp_out(8'h1E);
    repeat (25) @(negedge clk);
    chk("ready", 8'h01, {7'h0, rdy});
    $display("test codes done");
  endtask
  task automatic t_mode;
    wr(24'h9E013E, 3'h7);
    exp_out(8'h3E);
    repeat (45) @(negedge clk);
    chk("discharged", 8'h01, {7'h0, dis});
    wr(24'h9E01DE, 3'h7);
    exp_out(8'hDE);
    wr(24'h9E01C0, 3'h7);
    exp_out(8'hC0);
    wr(24'h9E0100, 3'h7);
    exp_out(8'h00);
    $display("test modes done");
  endtask
  task automatic t_refuse;
    wr(24'h9E011E, 3'h7);
    wr(24'h9C0105, 3'h0);
    wr(24'h9F0105, 3'h0);
    wr(24'h9E0205, 3'h4);
    exp_out(8'h1E);
    $display("test refuse done");
  endtask
  task automatic t_overvolt;
    repeat (25) @(negedge clk);
    overvolt = 1'b1;
    repeat (6) @(negedge clk);
    chk("pump overvolt", 8'h00, {7'h0, pump});
    chk("ready drop", 8'h00, {7'h0, rdy});
    overvolt = 1'b0;
    repeat (6) @(negedge clk);
    chk("pump back", 8'h01, {7'h0, pump});
    chk("ready restart", 8'h00, {7'h0, rdy});
    repeat (25) @(negedge clk);
    chk("ready", 8'h01, {7'h0, rdy});
    $display("test overvoltage done");
  endtask
  initial
  begin
    @(negedge clk);
    rst = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    exp_out(8'h00);
    chk("discharged", 8'h00, {7'h0, dis});
    $display("test reset done");
    t_codes;
    t_mode;
    t_refuse;
    t_overvolt;
    wrap_up;
  end
endmodule
